// ===== shared/clkctl_consts.svh
// Register indices, field positions, reset values, divider codes and VCO table settings
`ifndef CLKCTL_CONSTS_SVH
`define CLKCTL_CONSTS_SVH

`define IDX_CPU_CLOCK_CONFIG     16'hFF73
`define IDX_PLL_MULTIPLIER_CTRL  16'hFF9E
`define IDX_SYSTEM_CLOCK_CTRL    16'hFF9F

`define CFG_MODSEL_BIT           7
`define CFG_WAIT_MSB             6
`define CFG_WAIT_LSB             4
`define CFG_DIV_MSB              3
`define CFG_DIV_LSB              1
`define CFG_SHADOW_BIT           0

`define MUL_MODE_BIT             7
`define MUL_CODE_MSB             6
`define MUL_CODE_LSB             0

`define SYS_PLL_POWER_BIT        7
`define SYS_PLL_SELECT_BIT       6
`define SYS_XTAL_MSB             1
`define SYS_XTAL_LSB             0
`define SYS_WRITABLE_MASK        8'hC3

`define RST_CPU_CLOCK_CONFIG     8'h00
`define RST_PLL_MULTIPLIER_CTRL  8'h00
`define RST_SYSTEM_CLOCK_CTRL    8'h02

`define REF_DIV_CODE0            7'h10
`define REF_DIV_CODE1            7'h16
`define REF_DIV_CODE2            7'h20
`define REF_DIV_CODE3            7'h40
`define POST_DIV_MODE0           3'h4
`define POST_DIV_MODE1           3'h2

`define VCO_FIRST_CODE           7'h02
`define VCO_FIRST_MHZ            8'h03
`define VCO_ENTRIES              126

`endif

// ===== shared/clkctl_pkg.sv
// Types shared by the clock control design files
package clkctl_pkg;

  typedef enum logic [2:0] {
    RATIO_1   = 3'b000,
    RATIO_1P5 = 3'b001,
    RATIO_2   = 3'b010,
    RATIO_3   = 3'b011,
    RATIO_4   = 3'b100
  } ratio_t;

  typedef logic [127:0][7:0] freq_table_t;

  // Codes walk a 7-bit shift sequence with feedback from bits 6 and 3
  function automatic freq_table_t build_freq_table(
    input logic [6:0] first_code,
    input logic [7:0] first_mhz,
    input int         entries
  );
    freq_table_t t;
    logic [6:0]  x;
    logic [7:0]  f;
    t = '0;
    x = first_code;
    f = first_mhz;
    for (int i = 0; i < entries; i++) begin
      t[x] = f;
      x    = {x[5:0], x[6] ^ x[3]};
      f    = f + 8'h01;
    end
    return t;
  endfunction

endpackage

// ===== shared/cpu_clk_cfg_if.sv
// Divider and wait settings passed from the registers to the clock generator
`timescale 1ns/1ns
interface cpu_clk_cfg_if;
  logic [2:0] div_code;
  logic [2:0] wait_count;
  modport src (output div_code, output wait_count);
  modport gen (input div_code, input wait_count);
endinterface // cpu_clk_cfg_if

// ===== hdl/vco_code_rom.sv
// Multiplier code to VCO frequency table with registered read
`timescale 1ns/1ns
`include "clkctl_consts.svh"
module vco_code_rom
  import clkctl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Lookup
  input  wire logic [6:0] code,
  output logic      [7:0] mhz_q
);

  localparam freq_table_t TABLE = build_freq_table(`VCO_FIRST_CODE,
                                                   `VCO_FIRST_MHZ,
                                                   `VCO_ENTRIES);

  logic [7:0] mhz_d;

  // Codes outside the sequence read as zero
  always_comb begin
    mhz_d = TABLE[code];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mhz_q <= 8'h00;
    end else begin
      mhz_q <= mhz_d;
    end
  end

endmodule // vco_code_rom

// ===== hdl/cpu_clock_gen.sv
// Sub-CPU clock divider and wait state generator
`timescale 1ns/1ns
`include "clkctl_consts.svh"
module cpu_clock_gen
  import clkctl_pkg::*;
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   nrst,
  // Settings
  cpu_clk_cfg_if.gen  cfg,
  // Sub-CPU side
  input  wire logic   mem_req,
  output logic        cpu_clk_q,
  output logic        cpu_clk_gated_q,
  output logic        cpu_ready_q
);

  ratio_t     ratio_q, ratio_d;
  logic [1:0] phase_q, phase_d;
  logic [1:0] last;
  logic [2:0] wait_q,  wait_d;
  logic       clk_d, gated_d, ready_d;
  ratio_t     ratio_req;

  // Undefined codes above divide-by-4 fall back to divide-by-4
  always_comb begin
    unique case (cfg.div_code)
      3'b000:  ratio_req = RATIO_1;
      3'b001:  ratio_req = RATIO_1P5;
      3'b010:  ratio_req = RATIO_2;
      3'b011:  ratio_req = RATIO_3;
      default: ratio_req = RATIO_4;
    endcase
  end

  always_comb begin
    unique case (ratio_q)
      RATIO_1:   last = 2'd0;
      RATIO_1P5: last = 2'd2;
      RATIO_2:   last = 2'd1;
      RATIO_3:   last = 2'd2;
      RATIO_4:   last = 2'd3;
      default:   last = 2'd0;
    endcase
    ratio_d = ratio_q;
    phase_d = phase_q + 2'd1;
    // A new ratio is taken only at a period boundary, so no short pulse
    if (phase_q == last) begin // [RQ15]
      phase_d = 2'd0;
      ratio_d = ratio_req;
    end
    // Ratios 1 and 1.5 gate sysclk, so the pulse is its high phase
    gated_d = (ratio_d == RATIO_1) || (ratio_d == RATIO_1P5); // [RQ4]
    if (ratio_d == RATIO_1P5) begin
      clk_d = (phase_d != 2'd2); // [RQ3] [RQ4]
    end else if (ratio_d == RATIO_1) begin
      clk_d = 1'b1; // [RQ3]
    end else begin
      clk_d = (phase_d == 2'd0); // [RQ3] [RQ5]
    end
  end

  // Waits hold ready low for whole sub-CPU cycles; the clock never stretches
  always_comb begin
    wait_d  = wait_q;
    if (mem_req) begin
      wait_d = cfg.wait_count; // [RQ2]
    end else if (clk_d && wait_q != 3'd0) begin
      wait_d = wait_q - 3'd1; // [RQ1]
    end
    ready_d = (wait_d == 3'd0); // [RQ1] [RQ2]
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ratio_q         <= RATIO_1;
      phase_q         <= 2'd0;
      wait_q          <= 3'd0;
      cpu_clk_q       <= 1'b0;
      cpu_clk_gated_q <= 1'b1;
      cpu_ready_q     <= 1'b1;
    end else begin
      ratio_q         <= ratio_d;
      phase_q         <= phase_d;
      wait_q          <= wait_d;
      cpu_clk_q       <= clk_d;
      cpu_clk_gated_q <= gated_d;
      cpu_ready_q     <= ready_d;
    end
  end

endmodule // cpu_clock_gen

// ===== hdl/clock_control_top.sv
// System and sub-CPU clock control with its register slave
//
// Functional notes
// RQ1: Wait states never disturb sub-CPU clock timing.
// RQ2: Wait field bits 6:4 give 0-7 waits.
// RQ3: Divider bits 3:1 give ratios 1,1.5,2,3,4.
// RQ4: Ratios 1 and 1.5 pulse equals sysclk high.
// RQ5: Ratios 2,3,4 pulse high one sysclk cycle.
// RQ6: Bit 0 copies register writes into buffer RAM.
// RQ7: Bit 7 PLL power, bit 6 clock source; default 0.
// RQ8: Bit 6 set selects PLL multiplier clock.
// RQ9: Software avoids rewriting source bit after one.
// RQ10: Crystal field selects reference divider 16/22/32/64.
// RQ11: Crystal field resets to code 10, divide 32.
// RQ12: Seven-bit code maps to VCO MHz by table.
// RQ13: Multiplier bit 7 is separate mode bit.
// RQ14: Mode 0 divides VCO by 4, 1 by 2.
// RQ15: Switching never produces short clock pulses.
`timescale 1ns/1ns
`include "clkctl_consts.svh"
module clock_control_top
  import clkctl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Avalon-MM slave, word addressed
  input  wire logic [15:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Sub-CPU clock and wait states
  input  wire logic        cpu_mem_req,
  output logic             cpu_clk_q,
  output logic             cpu_clk_gated_q,
  output logic             cpu_ready_q,
  // PLL and system clock controls
  output logic             pll_power_q,
  output logic             sys_clk_from_pll_q,
  output logic      [6:0]  ref_divide_q,
  output logic      [6:0]  mult_code_q,
  output logic      [2:0]  post_divide_q,
  output logic      [7:0]  vco_mhz_q,
  // Buffer RAM shadow of register writes
  output logic             shadow_we_q,
  output logic      [15:0] shadow_addr_q,
  output logic      [7:0]  shadow_data_q
);

  cpu_clk_cfg_if cfg_bus ();

  logic [7:0]  cpu_cfg_q,  cpu_cfg_d;
  logic [7:0]  mul_ctl_q,  mul_ctl_d;
  logic [7:0]  sys_ctl_q,  sys_ctl_d;
  logic        wait_q,     wait_d;
  logic [31:0] rdata_q,    rdata_d;
  logic        shadow_we_d;
  logic [15:0] shadow_addr_d;
  logic [7:0]  shadow_data_d;
  logic [6:0]  ref_div_d;
  logic [2:0]  post_div_d;
  logic        pll_power_d;
  logic        src_pll_d;
  logic [6:0]  mult_code_d;
  logic        hit_cfg, hit_mul, hit_sys;
  logic        do_write;
  logic [7:0]  sel_data;

  // Register bus
  always_comb begin
    hit_cfg  = (address == `IDX_CPU_CLOCK_CONFIG);
    hit_mul  = (address == `IDX_PLL_MULTIPLIER_CTRL);
    hit_sys  = (address == `IDX_SYSTEM_CLOCK_CTRL);
    // A write lands on the edge where waitrequest is seen low
    do_write = write && !wait_q && byteenable[0];
    if (hit_cfg) begin
      sel_data = cpu_cfg_q;
    end else if (hit_mul) begin
      sel_data = mul_ctl_q;
    end else if (hit_sys) begin
      sel_data = sys_ctl_q & `SYS_WRITABLE_MASK;
    end else begin
      sel_data = 8'h00;
    end
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    if ((read || write) && wait_q) begin
      wait_d = 1'b0;
      if (read) begin
        rdata_d = {24'h000000, sel_data};
      end
    end
  end

  // Register contents
  always_comb begin
    cpu_cfg_d = cpu_cfg_q;
    mul_ctl_d = mul_ctl_q;
    sys_ctl_d = sys_ctl_q;
    if (do_write && hit_cfg) begin
      cpu_cfg_d = writedata[7:0]; // [RQ2] [RQ3] [RQ6]
    end
    if (do_write && hit_mul) begin
      mul_ctl_d = writedata[7:0]; // [RQ12] [RQ13]
    end
    if (do_write && hit_sys) begin
      sys_ctl_d = writedata[7:0] & `SYS_WRITABLE_MASK; // [RQ7] [RQ8]
    end
  end

  // Shadow copy uses the setting in force before this write
  always_comb begin
    shadow_we_d   = 1'b0;
    shadow_addr_d = shadow_addr_q;
    shadow_data_d = shadow_data_q;
    if (do_write && (hit_cfg || hit_mul || hit_sys)
        && cpu_cfg_q[`CFG_SHADOW_BIT]) begin // [RQ6]
      shadow_we_d   = 1'b1;
      shadow_addr_d = address;
      shadow_data_d = writedata[7:0];
    end
  end

  // Derived PLL and source controls from the settings
  always_comb begin
    unique case (sys_ctl_q[`SYS_XTAL_MSB:`SYS_XTAL_LSB])
      2'b00: ref_div_d = `REF_DIV_CODE0; // [RQ10]
      2'b01: ref_div_d = `REF_DIV_CODE1; // [RQ10]
      2'b10: ref_div_d = `REF_DIV_CODE2; // [RQ10] [RQ11]
      2'b11: ref_div_d = `REF_DIV_CODE3; // [RQ10]
    endcase
    if (mul_ctl_q[`MUL_MODE_BIT]) begin
      post_div_d = `POST_DIV_MODE1; // [RQ14]
    end else begin
      post_div_d = `POST_DIV_MODE0; // [RQ14]
    end
    pll_power_d = sys_ctl_q[`SYS_PLL_POWER_BIT]; // [RQ7]
    src_pll_d   = sys_ctl_q[`SYS_PLL_SELECT_BIT]; // [RQ7] [RQ8]
    mult_code_d = mul_ctl_q[`MUL_CODE_MSB:`MUL_CODE_LSB]; // [RQ13]
  end

  // Bus handshake state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // Register contents
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_cfg_q <= `RST_CPU_CLOCK_CONFIG;
      mul_ctl_q <= `RST_PLL_MULTIPLIER_CTRL;
      sys_ctl_q <= `RST_SYSTEM_CLOCK_CTRL; // [RQ7] [RQ11]
    end else begin
      cpu_cfg_q <= cpu_cfg_d;
      mul_ctl_q <= mul_ctl_d;
      sys_ctl_q <= sys_ctl_d;
    end
  end

  // Shadow write port
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shadow_we_q   <= 1'b0;
      shadow_addr_q <= 16'h0000;
      shadow_data_q <= 8'h00;
    end else begin
      shadow_we_q   <= shadow_we_d;
      shadow_addr_q <= shadow_addr_d;
      shadow_data_q <= shadow_data_d;
    end
  end

  // Derived outputs lag the registers by one cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pll_power_q        <= 1'b0;
      sys_clk_from_pll_q <= 1'b0;
      ref_divide_q       <= `REF_DIV_CODE2;
      mult_code_q        <= 7'h00;
      post_divide_q      <= `POST_DIV_MODE0;
    end else begin
      pll_power_q        <= pll_power_d;
      sys_clk_from_pll_q <= src_pll_d;
      ref_divide_q       <= ref_div_d;
      mult_code_q        <= mult_code_d;
      post_divide_q      <= post_div_d;
    end
  end

  assign readdata    = rdata_q;
  assign waitrequest = wait_q;

  assign cfg_bus.div_code   = cpu_cfg_q[`CFG_DIV_MSB:`CFG_DIV_LSB];
  assign cfg_bus.wait_count = cpu_cfg_q[`CFG_WAIT_MSB:`CFG_WAIT_LSB];

  cpu_clock_gen cpu_clock_gen_i (
    .clk             (clk),
    .nrst            (nrst),
    .cfg             (cfg_bus.gen),
    .mem_req         (cpu_mem_req),
    .cpu_clk_q       (cpu_clk_q),
    .cpu_clk_gated_q (cpu_clk_gated_q),
    .cpu_ready_q     (cpu_ready_q)
  );

  // Table lookup follows the code register by one cycle
  vco_code_rom vco_code_rom_i (
    .clk   (clk),
    .nrst  (nrst),
    .code  (mul_ctl_q[`MUL_CODE_MSB:`MUL_CODE_LSB]), // [RQ12]
    .mhz_q (vco_mhz_q)
  );

endmodule // clock_control_top

// ===== testbench/clock_control_asserts.sv
// Concurrent checks on the clock control top ports
`timescale 1ns/1ns
module clock_control_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Register bus
  input wire logic [15:0] address,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic        waitrequest,
  // Sub-CPU side
  input wire logic        cpu_clk_q,
  input wire logic        cpu_clk_gated_q,
  input wire logic        cpu_ready_q,
  // Clock controls and shadow write strobe
  input wire logic        pll_power_q,
  input wire logic        sys_clk_from_pll_q,
  input wire logic [6:0]  ref_divide_q,
  input wire logic [2:0]  post_divide_q,
  input wire logic        shadow_we_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  localparam logic [6:0] ref_tab [4] = '{7'h10, 7'h16, 7'h20, 7'h40};
  logic acc;
  logic sys_wr;
  logic mul_wr;
  assign acc    = write && !waitrequest && byteenable[0];
  assign sys_wr = acc && address == 16'hFF9F;
  assign mul_wr = acc && address == 16'hFF9E;

  chk_pll_power: assert property (
    sys_wr |-> ##2 pll_power_q == $past(writedata[7], 2))
    else $error("pll power differs from write");
  chk_source_sel: assert property (
    sys_wr |-> ##2 sys_clk_from_pll_q == $past(writedata[6], 2))
    else $error("clock source differs from write");
  chk_ref_div: assert property (
    sys_wr |-> ##2 ref_divide_q == ref_tab[$past(writedata[1:0], 2)])
    else $error("reference divider wrong");
  chk_post_div: assert property (
    mul_wr |-> ##2 post_divide_q == ($past(writedata[7], 2) ? 3'h2 : 3'h4))
    else $error("post divider wrong");
  chk_shadow_cause: assert property (
    shadow_we_q |-> $past(acc))
    else $error("shadow copy without a write");
  chk_high_one: assert property (
    !cpu_clk_gated_q [*2] ##0 cpu_clk_q |=> !cpu_clk_q)
    else $error("divided pulse longer than one cycle");
  chk_low_max: assert property (
    !cpu_clk_q [*4] |-> 1'b0)
    else $error("sub-CPU clock low beyond divide by 4");
  chk_wait_bound: assert property (
    $fell(cpu_ready_q) |-> ##[1:40] cpu_ready_q)
    else $error("wait states exceed seven pulses");
  chk_ready_on_pulse: assert property (
    $rose(cpu_ready_q) |-> cpu_clk_q)
    else $error("wait states end off a sub-CPU pulse");
  chk_switch_boundary: assert property (
    $changed(cpu_clk_gated_q) |-> cpu_clk_q)
    else $error("clock mode changed inside a period");
endmodule // clock_control_asserts

bind clock_control_top clock_control_asserts clock_control_asserts_i (
  .clk, .nrst, .address, .write, .writedata, .byteenable, .waitrequest,
  .cpu_clk_q, .cpu_clk_gated_q, .cpu_ready_q, .pll_power_q,
  .sys_clk_from_pll_q, .ref_divide_q, .post_divide_q, .shadow_we_q);

// ===== testbench/sub_cpu_model.sv
// Sub-CPU stand-in that starts memory accesses on its own clock
`timescale 1ns/1ns
module sub_cpu_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Clock and wait states from the block
  input  wire logic cpu_clk_q,
  input  wire logic cpu_ready_q,
  // Bench request and access strobe
  input  wire logic start,
  output logic      cpu_mem_req
);
  logic pend_q;
  logic pend_d;
  logic req_d;
  always_comb begin
    pend_d = pend_q | start;
    req_d  = 1'b0;
    // Access only on a clock pulse once earlier waits are over
    if (pend_q && cpu_clk_q && cpu_ready_q) begin
      req_d  = 1'b1;
      pend_d = start;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_q      <= 1'b0;
      cpu_mem_req <= 1'b0;
    end else begin
      pend_q      <= pend_d;
      cpu_mem_req <= req_d;
    end
  end
endmodule // sub_cpu_model

// ===== testbench/subcpu_and_system_clock_control_tb_top.sv
// Self-checking bench for the clock control block
`timescale 1ns/1ns
module subcpu_and_system_clock_control_tb_top;
  typedef struct packed {
    logic [15:0] a;
    logic [3:0]  be;
    logic [7:0]  d;
    logic [7:0]  r;
  } row_t;
  logic        clk, nrst, read, write, waitrequest, start, cpu_mem_req;
  logic        cpu_clk_q, cpu_clk_gated_q, cpu_ready_q;
  logic        pll_power_q, sys_clk_from_pll_q, shadow_we_q;
  logic [2:0]  post_divide_q;
  logic [3:0]  byteenable;
  logic [6:0]  ref_divide_q, mult_code_q;
  logic [7:0]  vco_mhz_q, shadow_data_q, q, sh_data;
  logic [15:0] address, shadow_addr_q, sh_addr;
  logic [31:0] writedata, readdata;
  int          bad_count, n_compared, cyc, sh_count, hi, k;
  localparam logic [6:0] ref_tab [4] = '{7'h10, 7'h16, 7'h20, 7'h40};
  localparam logic [7:0] mul_w [4] = '{8'h02, 8'hC0, 8'hC1, 8'h80};
  localparam logic [7:0] mul_f [4] = '{8'h03, 8'h80, 8'h20, 8'h00};
  localparam logic [3:0] highs [5] = '{4'hC, 4'h8, 4'h6, 4'h4, 4'h3};
  localparam logic [2:0] waits [3] = '{3'h0, 3'h3, 3'h7};
  // Bit 6 of the system register stays 0 here, see the last test
  localparam row_t rows [6] = '{
    '{16'hFF73, 4'h1, 8'hF8, 8'hF8}, '{16'hFF9E, 4'h1, 8'hC0, 8'hC0},
    '{16'hFF9E, 4'h0, 8'h2A, 8'hC0}, '{16'hFF9F, 4'hF, 8'hBD, 8'h81},
    '{16'hFF74, 4'h1, 8'h5A, 8'h00}, '{16'hFF73, 4'h1, 8'h00, 8'h00}};

  clock_control_top clock_control_top_i (.clk, .nrst, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .cpu_mem_req,
    .cpu_clk_q, .cpu_clk_gated_q, .cpu_ready_q, .pll_power_q,
    .sys_clk_from_pll_q, .ref_divide_q, .mult_code_q, .post_divide_q,
    .vco_mhz_q, .shadow_we_q, .shadow_addr_q, .shadow_data_q);
  sub_cpu_model sub_cpu_model_i (.clk, .nrst, .cpu_clk_q, .cpu_ready_q,
    .start, .cpu_mem_req);

  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (shadow_we_q === 1'b1) begin
      sh_count++;
      sh_addr = shadow_addr_q;
      sh_data = shadow_data_q;
    end
    if (cyc == 8000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic check(input string n, input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // One whole Avalon cycle; starts after an edge so drops never collide
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [3:0] be, input logic [7:0] d,
                     output logic [7:0] r);
    @(posedge clk);
    address <= a;
    byteenable <= be;
    writedata <= {24'h000000, d};
    write <= w;
    read <= !w;
    do @(posedge clk); while (waitrequest !== 1'b0);
    r = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    {clk, nrst, read, write, start} = '0;
    address = '0;
    writedata = '0;
    byteenable = '0;
    tick(3);
    nrst <= 1'b1;
    @(posedge clk);
    check("ref_div", ref_divide_q, 7'h20);
    check("src_pwr", {pll_power_q, sys_clk_from_pll_q}, 2'b00);
    bus(1'b0, 16'hFF9F, 4'h1, 8'h00, q);
    check("sys_reg", q, 8'h02);
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].be, rows[i].d, q);
      bus(1'b0, rows[i].a, 4'h1, 8'h00, q);
      check("readback", q, rows[i].r);
    end
    $display("test registers done");
    for (k = 0; k < 4; k++) begin
      bus(1'b1, 16'hFF9F, 4'h1, 8'(k), q);
      tick(3);
      check("ref_div", ref_divide_q, ref_tab[k]);
      bus(1'b1, 16'hFF9E, 4'h1, mul_w[k], q);
      tick(4);
      check("vco_mhz", vco_mhz_q, mul_f[k]);
      check("post_div", post_divide_q, mul_w[k][7] ? 3'h2 : 3'h4);
      check("mult_code", mult_code_q, mul_w[k][6:0]);
    end
    $display("test pll settings done");
    for (k = 0; k < 5; k++) begin
      bus(1'b1, 16'hFF73, 4'h1, 8'(k << 1), q);
      tick(8);
      hi = 0;
      repeat (12) begin
        @(posedge clk);
        hi += cpu_clk_q;
      end
      check("cpu_pulses", 16'(hi), highs[k]);
      check("gate_mode", cpu_clk_gated_q, k < 2);
    end
    $display("test divider done");
    foreach (waits[i]) begin
      bus(1'b1, 16'hFF73, 4'h1, {1'b0, waits[i], 4'h4}, q);
      tick(4);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      hi = 0;
      repeat (40) begin
        @(posedge clk);
        hi += (cpu_clk_q && !cpu_ready_q);
      end
      check("wait_pulses", 16'(hi), waits[i]);
    end
    $display("test wait states done");
    bus(1'b1, 16'hFF73, 4'h1, 8'h01, q);
    bus(1'b1, 16'hFF9E, 4'h1, 8'h11, q);
    tick(3);
    check("shadow_addr", sh_addr, 16'hFF9E);
    check("shadow_data", sh_data, 8'h11);
    bus(1'b1, 16'hFF73, 4'h1, 8'h00, q);
    bus(1'b1, 16'hFF9E, 4'h1, 8'h22, q);
    tick(3);
    check("shadow_count", 16'(sh_count), 16'h0002);
    $display("test shadow done");
    // Source select goes to one once only; rewrites are unreliable
    bus(1'b1, 16'hFF9F, 4'h1, 8'hC2, q);
    tick(3);
    check("src_pwr", {pll_power_q, sys_clk_from_pll_q}, 2'b11);
    $display("test source done");
    final_report();
  end
endmodule // subcpu_and_system_clock_control_tb_top
